// ### logic/monitor_defs.svh
// Constants for the monitor-mode entry and security block
// Operation
// RULE_01: Forced entry ignores serial-select and mode-select pins
// RULE_02: Blank vector: user exit, then extra reset
// RULE_03: Erased vector fetch asserts internal reset
// RULE_04: Non-power-on resets return to forced monitor
// RULE_05: Entry issues software interrupt then push-index-high
// RULE_06: Run issues pull-index-high then return-from-interrupt
// RULE_07: Host may rewrite stacked registers before run
// RULE_08: Read stack pointer returns stack pointer plus one
// RULE_09: Stacked PC high at SP+5, low SP+6
// RULE_10: After power-on entry, await eight serial security bytes
// RULE_11: Compare bytes to stored eight; full match bypasses
// RULE_12: Bypass allows host reads and program execution
// RULE_13: Bypass lasts until power-on reset only
// RULE_14: Any mismatch keeps security and blocks reads
// RULE_15: Serial baud is bus clock over 256
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
`define MON_BAUD_DIV 9'h100
`define MON_HALF_BIT 9'h080
`define MON_BIT_LAST 9'h0FF
`define MON_ERASED_VECTOR 16'hFFFF
`define MON_SEC_BASE 16'hFFF6
`define MON_SEC_LAST 3'h7
`define MON_SP_READ_OFS 16'h0001
`define MON_PC_HI_OFS 16'h0005
`define MON_PC_LO_OFS 16'h0006
`define MON_INT_RST_CYCLES 3'h4
`endif

// ### logic/monitor_entry_security.sv
// Monitor-mode entry, forced monitor detection and security check
`timescale 1ns/1ns
`include "monitor_defs.svh"
module monitor_entry_security (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire monitor_pkg::reset_event_t resetEvent,
  input wire logic monitorTestVoltage,
  input wire logic serialSelectPin,
  input wire logic modeSelectPinOne,
  input wire logic modeSelectPinZero,
  input wire monitor_pkg::vector_fetch_t vectorFetch,
  input wire monitor_pkg::mon_cmd_t monCmd,
  input wire logic monitorSerialPin,
  input wire logic [7:0] secData,
  output logic [15:0] secAddr,
  output logic internalReset,
  output logic monitorMode,
  output logic forcedMonitor,
  output logic securityBypassed,
  output logic flashReadAllow,
  output logic flashExecAllow,
  output monitor_pkg::instr_req_t instrReq,
  output monitor_pkg::sp_resp_t spResp,
  output logic [15:0] pcHighAddr,
  output logic [15:0] pcLowAddr
);
  logic byteValid;       // Security byte received
  logic [7:0] byteData;  // Received security byte

  monitor_pkg::mon_state_t state, next_state; // Sequencer phase
  logic [2:0] rstCnt, next_rstCnt;            // Internal reset width
  logic [2:0] secIdx, next_secIdx;            // Security byte position
  logic secMatch, next_secMatch;              // All bytes so far matched
  logic next_internalReset;
  logic next_monitorMode;
  logic next_forcedMonitor;
  logic next_securityBypassed;
  logic next_flashReadAllow;
  logic next_flashExecAllow;
  logic [15:0] next_secAddr;
  monitor_pkg::instr_req_t next_instrReq;
  monitor_pkg::sp_resp_t next_spResp;
  logic [15:0] next_pcHighAddr;
  logic [15:0] next_pcLowAddr;
  logic normalEntry;     // Full high-voltage monitor entry strapping
  logic forcedNow;       // Forced flag as seen by this reset event
  logic bypassNow;       // Bypass flag as seen by this reset event

  // Normal monitor entry checks all straps; used at every reset event
  function automatic logic normal_straps(input logic hiVolt, input logic serSel,
                                         input logic mOne, input logic mZero);
    normal_straps = hiVolt && !serSel && mZero && !mOne;
  endfunction

  // Running code match including the byte just received; one bad byte sticks
  function automatic logic byte_match(input logic soFar, input logic [7:0] got,
                                      input logic [7:0] stored);
    byte_match = soFar && (got == stored);
  endfunction

  // Serial receiver for the security bytes
  serial_byte_rx rxInst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .monitorSerialPin(monitorSerialPin),
    .byteValid(byteValid),
    .byteData(byteData)
  );

  // Sequencer: mode choice at reset, entry instructions, security, commands
  always_comb begin
    next_state = state;
    next_rstCnt = rstCnt;
    next_secIdx = secIdx;
    next_secMatch = secMatch;
    next_internalReset = 1'b0;
    next_monitorMode = monitorMode;
    next_forcedMonitor = forcedMonitor;
    next_securityBypassed = securityBypassed;
    next_instrReq = '0;
    next_spResp = '0;
    next_spResp.data = spResp.data;
    next_pcHighAddr = pcHighAddr;
    next_pcLowAddr = pcLowAddr;
    normalEntry = normal_straps(monitorTestVoltage, serialSelectPin,
                                modeSelectPinOne, modeSelectPinZero);
    // A power-on reset is the only thing that ends forced mode and bypass
    forcedNow = forcedMonitor && !resetEvent.powerOn; // [RULE_04]
    bypassNow = securityBypassed && !resetEvent.powerOn; // [RULE_13]
    if (resetEvent.valid) begin
      next_forcedMonitor = forcedNow;
      next_securityBypassed = bypassNow;
      next_secIdx = 3'h0;
      next_secMatch = 1'b1;
      if (normalEntry || forcedNow) begin
        // Forced entry takes no notice of the select pins
        next_state = monitor_pkg::ST_ENTER_INT; // [RULE_01] [RULE_04]
        next_monitorMode = 1'b1;
      end else begin
        // Blank part first leaves reset as a user part
        next_state = monitor_pkg::ST_USER; // [RULE_02]
        next_monitorMode = 1'b0;
      end
    end else begin
      case (state)
        monitor_pkg::ST_USER: begin
          // Vector fetch reading erased, with no test voltage
          if (vectorFetch.valid && vectorFetch.data == `MON_ERASED_VECTOR &&
              !monitorTestVoltage) begin
            next_state = monitor_pkg::ST_INT_RESET; // [RULE_03] [RULE_02]
            next_forcedMonitor = 1'b1;
            next_internalReset = 1'b1;
            next_rstCnt = 3'h1;
          end
        end
        monitor_pkg::ST_INT_RESET: begin
          // Hold the internal reset a few cycles; release is reported as a
          // non-power-on reset event, which lands in forced monitor
          next_internalReset = (rstCnt != `MON_INT_RST_CYCLES); // [RULE_03]
          next_rstCnt = rstCnt + 3'h1;
          if (rstCnt == `MON_INT_RST_CYCLES) begin
            next_rstCnt = rstCnt;
          end
        end
        monitor_pkg::ST_ENTER_INT: begin
          next_instrReq.valid = 1'b1;
          next_instrReq.code = monitor_pkg::SOFTWARE_INTERRUPT_INSTR; // [RULE_05]
          next_state = monitor_pkg::ST_ENTER_PUSH;
        end
        monitor_pkg::ST_ENTER_PUSH: begin
          next_instrReq.valid = 1'b1;
          next_instrReq.code = monitor_pkg::PUSH_INDEX_HIGH_INSTR; // [RULE_05]
          // An already bypassed part skips code entry
          next_state = securityBypassed ? monitor_pkg::ST_MON_IDLE
                                        : monitor_pkg::ST_SEC_WAIT; // [RULE_10] [RULE_13]
        end
        monitor_pkg::ST_SEC_WAIT: begin
          if (byteValid) begin
            // Stored byte for this position is on secData by now
            next_secMatch = byte_match(secMatch, byteData, secData); // [RULE_11]
            next_secIdx = secIdx + 3'h1;
            if (secIdx == `MON_SEC_LAST) begin
              next_state = monitor_pkg::ST_MON_IDLE;
              // A single wrong byte leaves the part secured
              next_securityBypassed = byte_match(secMatch, byteData, secData); // [RULE_11] [RULE_14]
            end
          end
        end
        monitor_pkg::ST_MON_IDLE: begin
          if (monCmd.valid) begin
            if (monCmd.code == monitor_pkg::CMD_READ_SP) begin
              next_spResp.valid = 1'b1;
              next_spResp.data = monCmd.stackPointer + `MON_SP_READ_OFS; // [RULE_08]
              next_pcHighAddr = monCmd.stackPointer + `MON_PC_HI_OFS; // [RULE_09]
              next_pcLowAddr = monCmd.stackPointer + `MON_PC_LO_OFS; // [RULE_09]
            end else begin
              // Host has had its chance to rewrite the stacked frame
              next_state = monitor_pkg::ST_RUN_PULL; // [RULE_07]
            end
          end
        end
        monitor_pkg::ST_RUN_PULL: begin
          next_instrReq.valid = 1'b1;
          next_instrReq.code = monitor_pkg::PULL_INDEX_HIGH_INSTR; // [RULE_06]
          next_state = monitor_pkg::ST_RUN_RETURN;
        end
        monitor_pkg::ST_RUN_RETURN: begin
          next_instrReq.valid = 1'b1;
          next_instrReq.code = monitor_pkg::RETURN_FROM_INTERRUPT_INSTR; // [RULE_06]
          // Core resumes at the stacked program counter, still monitored
          next_state = monitor_pkg::ST_MON_IDLE;
        end
        default: begin
          next_state = monitor_pkg::ST_USER;
        end
      endcase
    end
    // Access gates follow the bypass flag as it will be next cycle
    next_flashReadAllow = next_securityBypassed || !next_monitorMode; // [RULE_12] [RULE_14]
    next_flashExecAllow = next_securityBypassed || !next_monitorMode; // [RULE_12]
    next_secAddr = `MON_SEC_BASE + {13'h0000, next_secIdx}; // [RULE_11]
  end

  // Sequencer registers; asynchronous reset acts as power-on
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= monitor_pkg::ST_USER;
      rstCnt <= 3'h0;
      secIdx <= 3'h0;
      secMatch <= 1'b1;
      internalReset <= 1'b0;
      monitorMode <= 1'b0;
      forcedMonitor <= 1'b0;
      securityBypassed <= 1'b0;
      flashReadAllow <= 1'b1;
      flashExecAllow <= 1'b1;
      secAddr <= `MON_SEC_BASE;
      instrReq <= '0;
      spResp <= '0;
      pcHighAddr <= 16'h0000;
      pcLowAddr <= 16'h0000;
    end else begin
      state <= next_state;
      rstCnt <= next_rstCnt;
      secIdx <= next_secIdx;
      secMatch <= next_secMatch;
      internalReset <= next_internalReset;
      monitorMode <= next_monitorMode;
      forcedMonitor <= next_forcedMonitor;
      securityBypassed <= next_securityBypassed;
      flashReadAllow <= next_flashReadAllow;
      flashExecAllow <= next_flashExecAllow;
      secAddr <= next_secAddr;
      instrReq <= next_instrReq;
      spResp <= next_spResp;
      pcHighAddr <= next_pcHighAddr;
      pcLowAddr <= next_pcLowAddr;
    end
  end
endmodule

// ### logic/monitor_pkg.sv
// Types shared by the monitor-mode entry and security block
package monitor_pkg;
  typedef enum logic [2:0] {ST_USER, ST_INT_RESET, ST_ENTER_INT, ST_ENTER_PUSH, ST_SEC_WAIT,
                            ST_MON_IDLE, ST_RUN_PULL, ST_RUN_RETURN} mon_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {SOFTWARE_INTERRUPT_INSTR, PUSH_INDEX_HIGH_INSTR,
                            PULL_INDEX_HIGH_INSTR, RETURN_FROM_INTERRUPT_INSTR} instr_t;
  typedef enum logic {CMD_RUN, CMD_READ_SP} mon_cmd_code_t;
  // Reset completion report from the reset controller
  typedef struct packed {
    logic valid;
    logic powerOn;
  } reset_event_t;
  // Reset vector fetch observed on the core bus
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } vector_fetch_t;
  // Monitor command decoded by the monitor firmware
  typedef struct packed {
    logic valid;
    mon_cmd_code_t code;
    logic [15:0] stackPointer;
  } mon_cmd_t;
  // Instruction forced into the core
  typedef struct packed {
    logic valid;
    instr_t code;
  } instr_req_t;
  // Answer to a read-stack-pointer command
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sp_resp_t;
endpackage

// ### logic/serial_byte_rx.sv
// Single-wire monitor serial receiver, bit time of 256 bus cycles
`timescale 1ns/1ns
`include "monitor_defs.svh"
module serial_byte_rx (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic monitorSerialPin,
  output logic byteValid,
  output logic [7:0] byteData
);
  monitor_pkg::rx_state_t state, next_state; // Receiver phase
  logic [8:0] bitCnt, next_bitCnt;          // Cycles within the current bit
  logic [2:0] bitIdx, next_bitIdx;          // Data bit being shifted
  logic [7:0] shiftReg, next_shiftReg;      // Assembled byte, LSB first
  logic next_byteValid;
  logic [7:0] next_byteData;

  // Next-state logic; one bit time is the bus clock divided by 256
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt + 9'h001;
    next_bitIdx = bitIdx;
    next_shiftReg = shiftReg;
    next_byteValid = 1'b0;
    next_byteData = byteData;
    case (state)
      monitor_pkg::RX_IDLE: begin
        next_bitCnt = 9'h000;
        // Line idles high through its pull-up, start bit is low
        if (!monitorSerialPin) begin
          next_state = monitor_pkg::RX_START;
        end
      end
      monitor_pkg::RX_START: begin
        // Recheck at mid-bit so a glitch does not start a frame
        if (bitCnt == `MON_HALF_BIT) begin
          next_bitCnt = 9'h000;
          next_bitIdx = 3'h0;
          next_state = monitorSerialPin ? monitor_pkg::RX_IDLE : monitor_pkg::RX_DATA;
        end
      end
      monitor_pkg::RX_DATA: begin
        if (bitCnt == `MON_BIT_LAST) begin // [RULE_15]
          next_bitCnt = 9'h000;
          next_shiftReg = {monitorSerialPin, shiftReg[7:1]};
          next_bitIdx = bitIdx + 3'h1;
          if (bitIdx == 3'h7) begin
            next_state = monitor_pkg::RX_STOP;
          end
        end
      end
      monitor_pkg::RX_STOP: begin
        if (bitCnt == `MON_BIT_LAST) begin // [RULE_15]
          next_state = monitor_pkg::RX_IDLE;
          // Framing errors drop the byte silently
          if (monitorSerialPin) begin
            next_byteValid = 1'b1;
            next_byteData = shiftReg;
          end
        end
      end
      default: begin
        next_state = monitor_pkg::RX_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= monitor_pkg::RX_IDLE;
      bitCnt <= 9'h000;
      bitIdx <= 3'h0;
      shiftReg <= 8'h00;
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      bitIdx <= next_bitIdx;
      shiftReg <= next_shiftReg;
      byteValid <= next_byteValid;
      byteData <= next_byteData;
    end
  end
endmodule

// ### verification/monitor_entry_security_asserts.sv
// Port-level checker for the monitor entry and security block
`timescale 1ns/1ns
`include "monitor_defs.svh"
module monitor_entry_security_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire monitor_pkg::reset_event_t resetEvent,
  input wire logic monitorTestVoltage,
  input wire monitor_pkg::vector_fetch_t vectorFetch,
  input wire monitor_pkg::mon_cmd_t monCmd,
  input wire logic internalReset,
  input wire logic monitorMode,
  input wire logic forcedMonitor,
  input wire logic securityBypassed,
  input wire logic flashReadAllow,
  input wire logic flashExecAllow,
  input wire monitor_pkg::instr_req_t instrReq,
  input wire monitor_pkg::sp_resp_t spResp,
  input wire logic [15:0] pcHighAddr,
  input wire logic [15:0] pcLowAddr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Erased vector fetched in plain user mode; a reset event would win
  logic blankFetch;
  assign blankFetch = vectorFetch.valid && vectorFetch.data == `MON_ERASED_VECTOR
    && !monitorTestVoltage && !monitorMode && !forcedMonitor && !internalReset
    && !resetEvent.valid;
  property p_intRst; blankFetch |=> internalReset [*4] ##1 !internalReset; endproperty
  a_intRst: assert property (p_intRst) else $error("internal reset width");
  property p_forced; blankFetch |=> forcedMonitor; endproperty
  a_forced: assert property (p_forced) else $error("forced mode not latched");
  property p_warm; resetEvent.valid && !resetEvent.powerOn && forcedMonitor
    |=> forcedMonitor && monitorMode; endproperty
  a_warm: assert property (p_warm) else $error("forced mode lost");
  property p_por; resetEvent.valid && resetEvent.powerOn
    |=> !forcedMonitor && !securityBypassed; endproperty
  a_por: assert property (p_por) else $error("power-on reset kept state");
  property p_keep; resetEvent.valid && !resetEvent.powerOn && securityBypassed
    |=> securityBypassed; endproperty
  a_keep: assert property (p_keep) else $error("bypass lost on warm reset");
  property p_entry; $rose(monitorMode)
    |=> instrReq == {1'b1, monitor_pkg::SOFTWARE_INTERRUPT_INSTR}
    ##1 instrReq == {1'b1, monitor_pkg::PUSH_INDEX_HIGH_INSTR}; endproperty
  a_entry: assert property (p_entry) else $error("entry sequence wrong");
  property p_run; instrReq == {1'b1, monitor_pkg::PULL_INDEX_HIGH_INSTR}
    |-> $past(monCmd.valid, 2)
    ##1 instrReq == {1'b1, monitor_pkg::RETURN_FROM_INTERRUPT_INSTR}; endproperty
  a_run: assert property (p_run) else $error("run sequence wrong");
  property p_sp; spResp.valid |-> spResp.data == $past(monCmd.stackPointer) + 16'h0001
    && pcHighAddr == $past(monCmd.stackPointer) + 16'h0005
    && pcLowAddr == $past(monCmd.stackPointer) + 16'h0006; endproperty
  a_sp: assert property (p_sp) else $error("stack pointer answer wrong");
  property p_allow; flashReadAllow == (securityBypassed || !monitorMode)
    && flashExecAllow == flashReadAllow; endproperty
  a_allow: assert property (p_allow) else $error("flash access gate wrong");
  c_entry: cover property ($rose(monitorMode));
  c_bypass: cover property ($rose(securityBypassed));
  c_sp: cover property (spResp.valid);
endmodule
bind monitor_entry_security monitor_entry_security_asserts u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .resetEvent(resetEvent),
  .monitorTestVoltage(monitorTestVoltage), .vectorFetch(vectorFetch), .monCmd(monCmd),
  .internalReset(internalReset), .monitorMode(monitorMode), .forcedMonitor(forcedMonitor),
  .securityBypassed(securityBypassed), .flashReadAllow(flashReadAllow),
  .flashExecAllow(flashExecAllow), .instrReq(instrReq), .spResp(spResp),
  .pcHighAddr(pcHighAddr), .pcLowAddr(pcLowAddr)
);

// ### verification/monitor_entry_security_test.sv
// Self-checking bench for monitor entry and security
`timescale 1ns/1ns
module monitor_entry_security_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  monitor_pkg::reset_event_t resetEvent = '0;
  logic monitorTestVoltage = 1'b0;
  logic serialSelectPin = 1'b0;
  logic modeSelectPinOne = 1'b0;
  logic modeSelectPinZero = 1'b1;
  monitor_pkg::vector_fetch_t vectorFetch = '0;
  monitor_pkg::mon_cmd_t monCmd = '0;
  logic monitorSerialPin;
  logic [7:0] secData;
  logic [15:0] secAddr;
  logic [15:0] pcHighAddr;
  logic [15:0] pcLowAddr;
  logic internalReset;
  logic monitorMode;
  logic forcedMonitor;
  logic securityBypassed;
  logic flashReadAllow;
  logic flashExecAllow;
  monitor_pkg::instr_req_t instrReq;
  monitor_pkg::sp_resp_t spResp;
  // Stored code bytes at the top of program memory
  logic [7:0] secMem [8] = '{8'h3C, 8'hA5, 8'h01, 8'hFE, 8'h5A, 8'h80, 8'h7F, 8'hC3};
  int mismatches = 0;
  int nChecks = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  // Memory answers at once; low address bits minus 6 give the index
  always_comb secData = secMem[secAddr[2:0] - 3'h6];
  monitor_entry_security u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .resetEvent(resetEvent),
    .monitorTestVoltage(monitorTestVoltage), .serialSelectPin(serialSelectPin),
    .modeSelectPinOne(modeSelectPinOne), .modeSelectPinZero(modeSelectPinZero),
    .vectorFetch(vectorFetch), .monCmd(monCmd), .monitorSerialPin(monitorSerialPin),
    .secData(secData), .secAddr(secAddr), .internalReset(internalReset),
    .monitorMode(monitorMode), .forcedMonitor(forcedMonitor),
    .securityBypassed(securityBypassed), .flashReadAllow(flashReadAllow),
    .flashExecAllow(flashExecAllow), .instrReq(instrReq), .spResp(spResp),
    .pcHighAddr(pcHighAddr), .pcLowAddr(pcLowAddr)
  );
  monitor_host_model u_host (.core_clk(core_clk), .monitorSerialPin(monitorSerialPin));
  task automatic check(input string what, input logic [16:0] expected, input logic [16:0] seen);
    nChecks++;
    if (seen !== expected) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, expected, seen);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Cuts a hang short; the three scenarios need about 41000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 50000) begin
      mismatches++;
      give_verdict();
    end
  end
  // One-cycle reset completion report
  task automatic sendEvent(input logic por);
    @(negedge core_clk);
    resetEvent = '{valid: 1'b1, powerOn: por};
    @(negedge core_clk);
    resetEvent = '0;
  endtask
  // Monitor level, then the two forced instructions
  task automatic checkEntry();
    check("monitorMode", 17'h1, 17'(monitorMode));
    check("secAddrFirst", 17'h0FFF6, 17'(secAddr));
    @(negedge core_clk);
    check("softIntInstr", 17'h4, 17'(instrReq));
    @(negedge core_clk);
    check("pushHighInstr", 17'h5, 17'(instrReq));
  endtask
  // Eight code bytes; a bad run flips a bit of the last one
  task automatic sendBytes(input logic bad);
    for (int i = 0; i < 8; i++) begin
      u_host.sendByte(secMem[i] ^ {7'h0, bad && i == 7});
    end
    repeat (4) @(negedge core_clk);
  endtask
  // Blank vector without test voltage, odd straps, good code
  task automatic t_forcedEntry();
    sendEvent(1'b1);
    check("userAfterPor", 17'h0, 17'(monitorMode));
    vectorFetch = '{valid: 1'b1, data: 16'hFFFF};
    @(negedge core_clk);
    vectorFetch = '0;
    repeat (4) begin
      check("intReset", 17'h1, 17'(internalReset));
      @(negedge core_clk);
    end
    check("intResetEnd", 17'h0, 17'(internalReset));
    check("forced", 17'h1, 17'(forcedMonitor));
    serialSelectPin = 1'b1;
    modeSelectPinOne = 1'b1;
    modeSelectPinZero = 1'b0;
    sendEvent(1'b0);
    checkEntry();
    sendBytes(1'b0);
    check("bypassed", 17'h1, 17'(securityBypassed));
    check("readAllow", 17'h1, 17'(flashReadAllow));
    check("execAllow", 17'h1, 17'(flashExecAllow));
  endtask
  // Warm reset keeps forced mode and bypass, then commands
  task automatic t_warmCommands();
    sendEvent(1'b0);
    checkEntry();
    check("forcedKept", 17'h1, 17'(forcedMonitor));
    check("bypassKept", 17'h1, 17'(securityBypassed));
    @(negedge core_clk);
    monCmd = '{valid: 1'b1, code: monitor_pkg::CMD_READ_SP, stackPointer: 16'h00FF};
    @(negedge core_clk);
    monCmd = '0;
    check("spResp", 17'h10100, 17'(spResp));
    check("pcHigh", 17'h0104, 17'(pcHighAddr));
    check("pcLow", 17'h0105, 17'(pcLowAddr));
    // Stacked frame is left as pushed; the host is free to rewrite it first
    monCmd = '{valid: 1'b1, code: monitor_pkg::CMD_RUN, stackPointer: 16'h0000};
    @(negedge core_clk);
    monCmd = '0;
    @(negedge core_clk);
    check("pullHighInstr", 17'h6, 17'(instrReq));
    @(negedge core_clk);
    check("returnInstr", 17'h7, 17'(instrReq));
  endtask
  // Power-on normal entry clears state; a wrong code keeps the lock
  task automatic t_badCode();
    monitorTestVoltage = 1'b1;
    serialSelectPin = 1'b0;
    modeSelectPinOne = 1'b0;
    modeSelectPinZero = 1'b1;
    sendEvent(1'b1);
    checkEntry();
    check("forcedCleared", 17'h0, 17'(forcedMonitor));
    check("bypassCleared", 17'h0, 17'(securityBypassed));
    sendBytes(1'b1);
    check("locked", 17'h0, 17'(securityBypassed));
    check("readDenied", 17'h0, 17'(flashReadAllow));
    check("execDenied", 17'h0, 17'(flashExecAllow));
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    t_forcedEntry();
    t_warmCommands();
    t_badCode();
    give_verdict();
  end
endmodule

// ### verification/monitor_host_model.sv
// Host side of the single-wire monitor link
`timescale 1ns/1ns
module monitor_host_model (
  input wire logic core_clk,
  output logic monitorSerialPin
);
  // Pull-up holds the line high between frames
  initial monitorSerialPin = 1'b1;
  // One bit lasts one baud period
  task automatic holdBit(input logic level);
    monitorSerialPin = level;
    repeat (256) @(negedge core_clk);
  endtask
  // Start bit, data least significant first, stop bit
  task automatic sendByte(input logic [7:0] value);
    holdBit(1'b0);
    for (int i = 0; i < 8; i++) begin
      holdBit(value[i]);
    end
    holdBit(1'b1);
  endtask
endmodule
